/* File: hw/ahj_pkg.sv */
// Package of constants and types for the arithmetic, halt and jump unit
// =====================================================================
package ahj_pkg;
   // =================================================================
   // Widths
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   // =================================================================
   // Decimal adjust and increment/decrement constants
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [7:0] ADJ_LOW = 8'h06;
   localparam logic [7:0] ADJ_HIGH = 8'h60;
   localparam logic [7:0] ADJ_NONE = 8'h00;
   localparam logic [7:0] ONE = 8'h01;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   // =================================================================
   // Operation codes presented by decode
   typedef enum logic [2:0] {
      AHJ_OP_NONE = 3'h0,
      AHJ_OP_BCD_ADJ = 3'h1,
      AHJ_OP_MDEC = 3'h2,
      AHJ_OP_ACC_DOWN = 3'h3,
      AHJ_OP_MINC = 3'h4,
      AHJ_OP_ACC_UP = 3'h5,
      AHJ_OP_HALT = 3'h6,
      AHJ_OP_JUMP = 3'h7
   } ahj_op_t;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      AHJ_ST_RUN = 3'b001,
      AHJ_ST_DUMMY = 3'b010,
      AHJ_ST_HALT = 3'b100
   } ahj_state_t;
endpackage : ahj_pkg

/* File: hw/ahj_arith.sv */
// Combinational decimal adjust and increment/decrement datapath
`timescale 1ns/1ps
module ahj_arith
   import ahj_pkg::*;
(
   input wire ahj_op_t i_op,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_mem,
   input wire logic i_carry,
   input wire logic i_aux_carry_flag,
   output logic [7:0] o_result,
   output logic o_carry
);
   logic low_fix;
   logic high_fix;
   logic [8:0] daa_sum;
   // =================================================================
   // Nibble correction choice
   always_comb begin
      low_fix = (i_acc[3:0] > BCD_MAX_DIGIT) || i_aux_carry_flag;
      high_fix = (i_acc[7:4] > BCD_MAX_DIGIT) || i_carry;
      daa_sum = {1'b0, i_acc} + {1'b0, (low_fix ? ADJ_LOW : ADJ_NONE)}
         + {1'b0, (high_fix ? ADJ_HIGH : ADJ_NONE)};
   end
   // =================================================================
   // Result select, all sums wrap at eight bits
   always_comb begin
      o_result = i_acc;
      o_carry = i_carry;
      unique case (i_op)
         AHJ_OP_BCD_ADJ: begin
            o_result = daa_sum[7:0];
            // Carry sticks if already set, or if the high nibble was above 9, or if the sum passes eight bits
            o_carry = i_carry | high_fix | daa_sum[8];
         end
         AHJ_OP_MDEC, AHJ_OP_ACC_DOWN: begin
            o_result = i_mem - ONE;
         end
         AHJ_OP_MINC, AHJ_OP_ACC_UP: begin
            o_result = i_mem + ONE;
         end
         default: o_result = i_acc;
      endcase
   end
endmodule : ahj_arith

/* File: hw/ahj_exec.sv */
// Execution unit for decimal adjust, inc/dec, power-down and jump
`timescale 1ns/1ps
module ahj_exec
   import ahj_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_valid,
   input wire ahj_op_t i_op,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [PC_W-1:0] i_jump_addr,
   input wire logic i_wake,
   input wire logic i_watchdog_timeout,
   input wire logic i_aux_carry_flag,
   output logic o_ready,
   output logic [7:0] o_acc,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata,
   output logic [PC_W-1:0] o_pc,
   output logic o_carry,
   output logic o_zero,
   output logic o_timeout_flag,
   output logic o_power_down_flag,
   output logic o_watchdog_clear,
   output logic o_clk_gate_off
);
   ahj_state_t state_q, state_d;
   logic [7:0] acc_q, acc_d;
   logic [7:0] wdata_q, wdata_d;
   logic we_q, we_d;
   logic [PC_W-1:0] pc_q, pc_d;
   logic carry_q, carry_d, zero_q, zero_d;
   logic to_q, to_d, pwrdn_q, pwrdn_d, wclr_q, wclr_d;
   logic [7:0] arith_res;
   logic arith_carry;
   logic [2:0] wake_sync_q;
   logic wake_seen;
   logic take;

   // =================================================================
   // Datapath
   ahj_arith u_arith (
      .i_op(i_op),
      .i_acc(acc_q),
      .i_mem(i_mem_rdata),
      .i_carry(carry_q),
      .i_aux_carry_flag(i_aux_carry_flag),
      .o_result(arith_res),
      .o_carry(arith_carry)
   );

   // =================================================================
   // Wake pin synchroniser, wake seen when stages two and three are both high
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_sync_q <= 3'h0;
      end else begin
         wake_sync_q <= {wake_sync_q[1:0], i_wake};
      end
   end
   assign wake_seen = wake_sync_q[1] & wake_sync_q[2];

   // Decode accepts only in run state; dummy and halt stall the fetch
   assign o_ready = (state_q == AHJ_ST_RUN);
   assign take = i_valid && o_ready;

   // =================================================================
   // Next state of sequencer, registers and flags
   always_comb begin
      state_d = state_q;
      acc_d = acc_q;
      wdata_d = wdata_q;
      we_d = 1'b0;
      pc_d = pc_q;
      carry_d = carry_q;
      zero_d = zero_q;
      to_d = to_q | i_watchdog_timeout;
      pwrdn_d = pwrdn_q;
      wclr_d = 1'b0;
      unique case (state_q)
         AHJ_ST_RUN: begin
            if (take) begin
               pc_d = pc_q + 13'h0001;
               unique case (i_op)
                  AHJ_OP_BCD_ADJ: begin
                     wdata_d = arith_res;
                     we_d = 1'b1;
                     carry_d = arith_carry;
                  end
                  AHJ_OP_MDEC, AHJ_OP_MINC: begin
                     wdata_d = arith_res;
                     we_d = 1'b1;
                     zero_d = (arith_res == 8'h00);
                  end
                  AHJ_OP_ACC_DOWN, AHJ_OP_ACC_UP: begin
                     acc_d = arith_res;
                     zero_d = (arith_res == 8'h00);
                  end
                  AHJ_OP_HALT: begin
                     // Halt wins over a timeout in the same cycle
                     wclr_d = 1'b1;
                     to_d = 1'b0;
                     pwrdn_d = 1'b1;
                     state_d = AHJ_ST_HALT;
                  end
                  AHJ_OP_JUMP: begin
                     pc_d = i_jump_addr;
                     state_d = AHJ_ST_DUMMY;
                  end
                  default: pc_d = pc_q + 13'h0001;
               endcase
            end
         end
         AHJ_ST_DUMMY: state_d = AHJ_ST_RUN;
         AHJ_ST_HALT: begin
            // All state held except the timeout flag and the watchdog clear pulse; only a synchronised wake resumes
            if (wake_seen) begin
               state_d = AHJ_ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= AHJ_ST_RUN;
         acc_q <= ACC_RST;
         wdata_q <= ACC_RST;
         we_q <= 1'b0;
         pc_q <= PC_RST;
         carry_q <= 1'b0;
         zero_q <= 1'b0;
         to_q <= 1'b0;
         pwrdn_q <= 1'b0;
         wclr_q <= 1'b0;
      end else begin
         state_q <= state_d;
         acc_q <= acc_d;
         wdata_q <= wdata_d;
         we_q <= we_d;
         pc_q <= pc_d;
         carry_q <= carry_d;
         zero_q <= zero_d;
         to_q <= to_d;
         pwrdn_q <= pwrdn_d;
         wclr_q <= wclr_d;
      end
   end

   // =================================================================
   // Outputs
   assign o_acc = acc_q;
   assign o_mem_we = we_q;
   assign o_mem_wdata = wdata_q;
   assign o_pc = pc_q;
   assign o_carry = carry_q;
   assign o_zero = zero_q;
   assign o_timeout_flag = to_q;
   assign o_power_down_flag = pwrdn_q;
   assign o_watchdog_clear = wclr_q;
   assign o_clk_gate_off = (state_q == AHJ_ST_HALT);

   // =================================================================
   // Assertions
   a_halt_flags: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_HALT |=> o_power_down_flag && !o_timeout_flag
      && o_watchdog_clear && o_clk_gate_off)
      else $error("halt flag update wrong");
   a_jump_two_cycles: assert property (@(posedge i_ref_clk)
      disable iff (!i_arst_n)
      take && i_op == AHJ_OP_JUMP |=> !o_ready ##1 o_ready)
      else $error("jump not two cycles");
   a_jump_target: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_JUMP |=> o_pc == $past(i_jump_addr)
      && $stable(o_carry) && $stable(o_zero))
      else $error("jump target or flags wrong");
   a_inc_mem: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_MINC |=> o_mem_we
      && o_mem_wdata == 8'($past(i_mem_rdata) + 8'h01)
      && $stable(o_carry))
      else $error("increment to memory wrong");
   a_dec_mem: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_MDEC |=> o_mem_we
      && o_mem_wdata == 8'($past(i_mem_rdata) - 8'h01)
      && o_zero == (o_mem_wdata == 8'h00))
      else $error("decrement to memory wrong");
   a_inc_acc: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_ACC_UP |=> !o_mem_we
      && o_acc == 8'($past(i_mem_rdata) + 8'h01))
      else $error("increment to acc wrong");
   a_dec_acc: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_ACC_DOWN |=> !o_mem_we
      && o_acc == 8'($past(i_mem_rdata) - 8'h01)
      && o_zero == (o_acc == 8'h00))
      else $error("decrement to acc wrong");
   a_daa_low_fix: assert property (@(posedge i_ref_clk)
      disable iff (!i_arst_n)
      take && i_op == AHJ_OP_BCD_ADJ && o_acc[3:0] > 4'h9
      && o_acc[7:4] < 4'h9
      && !o_carry |=> o_mem_we && o_mem_wdata[3:0] == 4'($past(o_acc[3:0])
      + 4'h6) && $stable(o_zero))
      else $error("decimal adjust low nibble wrong");
   a_daa_carry: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      take && i_op == AHJ_OP_BCD_ADJ && o_acc[7:4] > 4'h9
      |=> o_carry)
      else $error("decimal adjust carry missing");
   a_halt_holds: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      o_clk_gate_off && !wake_seen |=> $stable(o_acc) && $stable(o_pc))
      else $error("state lost while halted");
   // =================================================================
   // Sequencing checks that the directed scenarios rarely stress
   // A no-operation only steps the pc; carry, zero and acc must not move
   a_none_steps_pc: assert property (@(posedge i_ref_clk)
      disable iff (!i_arst_n)
      take && i_op == AHJ_OP_NONE |=> o_ready && !o_mem_we
      && o_pc == $past(o_pc) + 13'h0001 && $stable(o_acc)
      && $stable(o_carry) && $stable(o_zero))
      else $error("no-operation changed state");
   // Watchdog clear is a single pulse, halting does not repeat it
   a_wdt_clear_pulse: assert property (@(posedge i_ref_clk)
      disable iff (!i_arst_n)
      o_watchdog_clear |=> !o_watchdog_clear)
      else $error("watchdog clear held too long");
   // Memory kept while halted: no write strobe may appear
   a_halt_no_write: assert property (@(posedge i_ref_clk)
      disable iff (!i_arst_n)
      o_clk_gate_off ##1 o_clk_gate_off |-> !o_mem_we)
      else $error("memory written while halted");
endmodule : ahj_exec

/* File: tb/ahj_exec_tb_top.sv */
// Self-checking bench for the arithmetic, halt and jump unit
`timescale 1ns/1ps
module ahj_exec_tb_top;
   import ahj_pkg::*;
   // ==============================================================
   // Expected outputs one cycle after an accepted operation
   typedef struct packed {
      logic rdy;
      logic we;
      logic [7:0] wd;
      logic [7:0] acc;
      logic c;
      logic z;
      logic [PC_W-1:0] pc;
      logic to;
      logic pwr;
      logic wclr;
      logic gate;
   } ahj_exp_t;
   logic i_ref_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_valid = 1'b0;
   ahj_op_t i_op = AHJ_OP_NONE;
   logic [7:0] i_mem_rdata = 8'h00;
   logic [PC_W-1:0] i_jump_addr = 13'h0000;
   logic i_wake = 1'b0;
   logic i_watchdog_timeout = 1'b0;
   logic i_aux_carry_flag = 1'b0;
   logic o_ready, o_mem_we, o_carry, o_zero, o_timeout_flag;
   logic o_power_down_flag, o_watchdog_clear, o_clk_gate_off;
   logic [7:0] o_acc, o_mem_wdata;
   logic [PC_W-1:0] o_pc;
   int mismatches = 0;
   int n_checks = 0;
   logic [31:0] seed = 32'hC9F7D7B4;
   ahj_exp_t q[$];
   ahj_exp_t m = '0;
   // Free-running 50 MHz clock
   always #10 i_ref_clk = ~i_ref_clk;
   ahj_exec dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
      .i_valid(i_valid), .i_op(i_op), .i_mem_rdata(i_mem_rdata),
      .i_jump_addr(i_jump_addr), .i_wake(i_wake),
      .i_watchdog_timeout(i_watchdog_timeout),
      .i_aux_carry_flag(i_aux_carry_flag),
      .o_ready(o_ready), .o_acc(o_acc), .o_mem_we(o_mem_we),
      .o_mem_wdata(o_mem_wdata), .o_pc(o_pc), .o_carry(o_carry),
      .o_zero(o_zero), .o_timeout_flag(o_timeout_flag),
      .o_power_down_flag(o_power_down_flag),
      .o_watchdog_clear(o_watchdog_clear), .o_clk_gate_off(o_clk_gate_off));
   // ==============================================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic cmp(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic finish_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   // Drives one op, waits for acceptance, notes what must follow
   task automatic op(input ahj_op_t o, input logic [7:0] d, input logic aux);
      logic [8:0] s;
      logic [7:0] adj;
      logic [PC_W-1:0] a;
      int n;
      a = PC_W'(xs());
      i_valid <= 1'b1;
      i_op <= o;
      i_mem_rdata <= d;
      i_aux_carry_flag <= aux;
      i_jump_addr <= a;
      i_watchdog_timeout <= (o != AHJ_OP_HALT) && seed[20];
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (o_ready !== 1'b1 && n < 50);
      @(posedge i_ref_clk);
      m.to = m.to | i_watchdog_timeout;
      m.rdy = 1'b1;
      m.we = 1'b0;
      m.wclr = 1'b0;
      m.gate = 1'b0;
      m.pc = m.pc + 1'b1;
      case (o)
         AHJ_OP_NONE: begin
            m.rdy = 1'b1;
         end
         AHJ_OP_BCD_ADJ: begin
            adj[3:0] = (m.acc[3:0] > 4'h9 || aux) ? 4'h6 : 4'h0;
            adj[7:4] = (m.acc[7:4] > 4'h9 || m.c) ? 4'h6 : 4'h0;
            s = {1'b0, m.acc} + {1'b0, adj};
            m.c = m.c | adj[5] | s[8];
            m.we = 1'b1;
            m.wd = s[7:0];
         end
         AHJ_OP_MDEC, AHJ_OP_MINC: begin
            m.we = 1'b1;
            m.wd = (o == AHJ_OP_MINC) ? d + 8'h01 : d - 8'h01;
            m.z = (m.wd == 8'h00);
         end
         AHJ_OP_ACC_DOWN, AHJ_OP_ACC_UP: begin
            m.acc = (o == AHJ_OP_ACC_UP) ? d + 8'h01 : d - 8'h01;
            m.z = (m.acc == 8'h00);
         end
         AHJ_OP_HALT: begin
            m.to = 1'b0;
            m.pwr = 1'b1;
            m.wclr = 1'b1;
            m.gate = 1'b1;
            m.rdy = 1'b0;
         end
         default: begin
            m.pc = a;
            m.rdy = 1'b0;
         end
      endcase
      q.push_back(m);
      // Wake pulse; valid dropped so a stale halt is not taken again
      if (o == AHJ_OP_HALT) begin
         @(posedge i_ref_clk);
         i_wake <= 1'b1;
         i_valid <= 1'b0;
         repeat (2) @(posedge i_ref_clk);
         i_wake <= 1'b0;
      end
   endtask : op
   // ==============================================================
   // Monitor compares each result with the oldest note
   always @(negedge i_ref_clk) begin
      ahj_exp_t e;
      if (q.size() > 0) begin
         e = q.pop_front();
         cmp("ready", 16'(e.rdy), 16'(o_ready));
         cmp("mem_we", 16'(e.we), 16'(o_mem_we));
         if (e.we) begin
            cmp("wdata", 16'(e.wd), 16'(o_mem_wdata));
            cmp("wdata_incdec", 16'(e.wd), 16'(o_mem_wdata));
         end
         cmp("acc", 16'(e.acc), 16'(o_acc));
         cmp("carry", 16'(e.c), 16'(o_carry));
         cmp("zero", 16'(e.z), 16'(o_zero));
         cmp("pc", 16'(e.pc), 16'(o_pc));
         cmp("to", 16'(e.to), 16'(o_timeout_flag));
         cmp("pwrdn", 16'(e.pwr), 16'(o_power_down_flag));
         cmp("wclr", 16'(e.wclr), 16'(o_watchdog_clear));
         cmp("gate", 16'(e.gate), 16'(o_clk_gate_off));
      end
   end
   // Watchdog, far beyond the expected several hundred cycles
   initial begin
      #(20 * 20000);
      mismatches++;
      finish_test();
   end
   // ==============================================================
   // Main sequence: reset, directed corners, then random ops
   initial begin
      logic [31:0] r;
      repeat (10) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      @(negedge i_ref_clk);
      cmp("rst", 16'h0001, {o_acc, o_pc[6:0], o_ready});
      @(posedge i_ref_clk);
      op(AHJ_OP_ACC_UP, 8'h98, 1'b0);
      op(AHJ_OP_BCD_ADJ, 8'h00, 1'b0);
      op(AHJ_OP_ACC_UP, 8'h99, 1'b0);
      op(AHJ_OP_BCD_ADJ, 8'h00, 1'b1);
      op(AHJ_OP_ACC_UP, 8'hFF, 1'b0);
      op(AHJ_OP_MINC, 8'hFF, 1'b0);
      op(AHJ_OP_MDEC, 8'h00, 1'b0);
      op(AHJ_OP_ACC_DOWN, 8'h01, 1'b0);
      op(AHJ_OP_NONE, 8'h55, 1'b1);
      op(AHJ_OP_ACC_UP, 8'hA8, 1'b0);
      op(AHJ_OP_BCD_ADJ, 8'h00, 1'b1);
      op(AHJ_OP_JUMP, 8'h00, 1'b0);
      op(AHJ_OP_HALT, 8'h00, 1'b0);
      repeat (300) begin
         r = xs();
         op(ahj_op_t'((r[2:0] == 3'h0) ? 3'h1 : r[2:0]), r[15:8], r[16]);
      end
      repeat (3) @(posedge i_ref_clk);
      finish_test();
   end
endmodule : ahj_exec_tb_top
